// file: common/spis_defs.vh
// Purpose: Shared constants for the sequence parameter and image stamp block.
// Assumes: 40 MHz core clock and 32-bit register words on a plain register port.
// Notes:   Offsets are byte addresses on the register port.
//
// Behaviour
// - Past the last entry, keep the last set; with auto reset set, wrap to entry zero.
// - Multi-shot or iso enable rewinds to entry zero.
// - Single shot restarts the sequence every shot.
// - Cancel invalidates entries; host reloads them.
// - Apply flag defaults every unconfigured entry parameter.
// - Stored entry values are never read back.
// - Sequence active: parameter writes go to selected entry.
// - Latch bus cycle time at integration start.
// - Trigger counter counts detected external triggers.
// - Frame counter counts frames read out.
// - Snapshot I/O lines at exposure start.
// - Write selected stamp items into chosen line.
// - Trigger and frame counters readable as registers.
// - Stamp carries sequence index when sequence active.
// - Reduced sizes crop sensor centre, no binning.
// - Binning combines two or four neighbouring pixels.
// - Frame starts never faster than exposure allows.
// - Step source: integration, edge, level; else integration.
// - Repeat count per entry; zero acts as one.
`ifndef SPIS_DEFS_VH
`define SPIS_DEFS_VH

`define SPIS_REG_SEQ_CTRL    8'h00
`define SPIS_REG_SEQ_PARAM   8'h04
`define SPIS_REG_SEQ_STEP    8'h08
`define SPIS_REG_ACQ_CMD     8'h0c
`define SPIS_REG_EXPOSURE    8'h10
`define SPIS_REG_GAIN        8'h14
`define SPIS_REG_AOI_ORIGIN  8'h18
`define SPIS_REG_AOI_SIZE    8'h1c
`define SPIS_REG_STAMP_CTRL  8'h20
`define SPIS_REG_USER_VALUE  8'h24
`define SPIS_REG_TRIG_COUNT  8'h28
`define SPIS_REG_FRAME_COUNT 8'h2c
`define SPIS_REG_SERIAL      8'h30
`define SPIS_REG_BINNING     8'h34
`define SPIS_REG_CYCLE_SNAP  8'h38

`define SPIS_SEQ_EN_BIT      0
`define SPIS_AUTO_RST_BIT    1
`define SPIS_APPLY_BIT       5
`define SPIS_PERF_STEP_BIT   5
`define SPIS_PERF_RESET_BIT  6
`define SPIS_CMD_SINGLE_BIT  0
`define SPIS_CMD_MULTI_BIT   1
`define SPIS_CMD_ISO_BIT     2
`define SPIS_STAMP_EN_BIT    15

`define SPIS_STEP_INTEG      8'h80
`define SPIS_STEP_EDGE       8'h82
`define SPIS_STEP_LEVEL      8'h84

`define SPIS_MAX_ENTRIES     8'h20
`define SPIS_SEQ_LEN_RST     8'h20
`define SPIS_EXP_RST_US      24'h009c40
`define SPIS_GAIN_RST        16'h0000
`define SPIS_SENSOR_W        16'h0290
`define SPIS_SENSOR_H        16'h01ec
`define SPIS_STAMP_WORDS     16'h0016
`define SPIS_STAMP_MASK_RST  11'h000
`define SPIS_STAMP_LINE_RST  16'h0000

`define SPIS_CLK_HZ          40000000
`define SPIS_CYC_PER_US      (`SPIS_CLK_HZ / 1000000)

`endif

// file: hw/spis_sync.v
// Purpose: Two-flop synchroniser for pin inputs.
// Assumes: Destination is the core clock domain.
// Notes:   Only the second stage may be read by logic.
`timescale 1ns/1ps
module spis_sync #(
  parameter W = 1
) (
  input  wire         core_clk_in,
  input  wire         rstn_in,
  input  wire [W-1:0] d_in,
  output reg  [W-1:0] q_out
);
  reg [W-1:0] meta_q;

  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_q <= {W{1'b0}};
      q_out  <= {W{1'b0}};
    end else begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end
endmodule

// file: hw/spis_top.v
// Purpose: Per-image parameter sequence, frame pacing, crop/binning and image stamp.
// Assumes: Sensor timing strobes and pixel stream share the core clock; pins do not.
// Notes:   Entry storage has no reset; validity bits guard it instead.
//
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "spis_defs.vh"
module spis_top (
  // Clock and reset
  input  wire        core_clk_in,
  input  wire        rstn_in,
  // Register port
  input  wire [7:0]  reg_addr_in,
  input  wire [31:0] reg_wdata_in,
  input  wire        reg_wr_in,
  input  wire        reg_rd_in,
  output reg  [31:0] reg_rdata_out,
  // External pins
  input  wire        ext_step_in,
  input  wire        ext_seq_reset_in,
  input  wire        ext_trigger_in,
  input  wire [7:0]  io_lines_in,
  // Sensor timing
  input  wire        integ_start_in,
  input  wire        readout_done_in,
  input  wire        frame_req_in,
  input  wire [31:0] cycle_time_in,
  output reg         frame_start_out,
  // Active parameter set
  output reg  [23:0] exposure_out,
  output reg  [15:0] gain_out,
  output reg  [7:0]  seq_index_out,
  // Pixel stream
  input  wire        pix_valid_in,
  input  wire        pix_sof_in,
  input  wire        pix_sol_in,
  input  wire [15:0] pix_data_in,
  output reg         pix_valid_out,
  output reg         pix_sol_out,
  output reg  [15:0] pix_data_out
);
  parameter [31:0] SERIAL_NUMBER = 32'h00001234; // Arbitrary value.

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection.
  wire       step_s;
  wire       rst_s;
  wire       trig_s;
  wire [7:0] io_s;
  reg        step_d_q;
  reg        rst_d_q;
  reg        trig_d_q;

  spis_sync #(.W(1)) u_sync_step (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
    .d_in(ext_step_in), .q_out(step_s));
  spis_sync #(.W(1)) u_sync_rst (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
    .d_in(ext_seq_reset_in), .q_out(rst_s));
  spis_sync #(.W(1)) u_sync_trig (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
    .d_in(ext_trigger_in), .q_out(trig_s));
  spis_sync #(.W(8)) u_sync_io (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
    .d_in(io_lines_in), .q_out(io_s));

  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      step_d_q <= 1'b0;
      rst_d_q  <= 1'b0;
      trig_d_q <= 1'b0;
    end else begin
      step_d_q <= step_s;
      rst_d_q  <= rst_s;
      trig_d_q <= trig_s;
    end
  end

  wire step_rise = step_s & ~step_d_q;
  wire rst_rise  = rst_s & ~rst_d_q;
  wire trig_rise = trig_s & ~trig_d_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes and sequence entry storage.
  reg        seq_en_q;
  reg        auto_rst_q;
  reg [7:0]  seq_len_q;
  reg [7:0]  img_sel_q;
  reg [23:0] exp_q;
  reg [15:0] gain_q;
  reg [31:0] origin_q;
  reg [31:0] size_q;
  reg [10:0] stamp_mask_q;
  reg        stamp_en_q;
  reg [15:0] stamp_line_q;
  reg [31:0] user_q;
  reg [1:0]  bin_mode_q;
  reg [3:0]  cfg_mask_q;
  reg [31:0] valid_q;

  reg [23:0] ent_exp    [0:31];
  reg [15:0] ent_gain   [0:31];
  reg [31:0] ent_origin [0:31];
  reg [31:0] ent_size   [0:31];
  reg [7:0]  ent_mode   [0:31];
  reg [7:0]  ent_rep    [0:31];

  wire       wr_hit   = reg_wr_in;
  wire [4:0] sel      = img_sel_q[4:0];
  wire [4:0] new_sel  = reg_wdata_in[28:24];
  wire       par_wr   = wr_hit && (reg_addr_in == `SPIS_REG_SEQ_PARAM);
  wire       step_wr  = wr_hit && (reg_addr_in == `SPIS_REG_SEQ_STEP);
  wire       cmd_wr   = wr_hit && (reg_addr_in == `SPIS_REG_ACQ_CMD);
  wire       apply    = par_wr && reg_wdata_in[`SPIS_APPLY_BIT];
  wire       seq_off  = wr_hit && (reg_addr_in == `SPIS_REG_SEQ_CTRL) &&
                        seq_en_q && !reg_wdata_in[`SPIS_SEQ_EN_BIT];

  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      seq_en_q     <= 1'b0;
      auto_rst_q   <= 1'b0;
      seq_len_q    <= `SPIS_SEQ_LEN_RST;
      img_sel_q    <= 8'h00;
      exp_q        <= `SPIS_EXP_RST_US;
      gain_q       <= `SPIS_GAIN_RST;
      origin_q     <= 32'h00000000;
      size_q       <= {`SPIS_SENSOR_H, `SPIS_SENSOR_W};
      stamp_mask_q <= `SPIS_STAMP_MASK_RST;
      stamp_en_q   <= 1'b0;
      stamp_line_q <= `SPIS_STAMP_LINE_RST;
      user_q       <= 32'h00000000;
      bin_mode_q   <= 2'h0;
      cfg_mask_q   <= 4'h0;
      valid_q      <= 32'h00000000;
    end else if (wr_hit) begin
      case (reg_addr_in)
        `SPIS_REG_SEQ_CTRL: begin
          seq_en_q   <= reg_wdata_in[`SPIS_SEQ_EN_BIT];
          auto_rst_q <= reg_wdata_in[`SPIS_AUTO_RST_BIT];
          seq_len_q  <= reg_wdata_in[23:16];
          if (seq_off) begin
            valid_q <= 32'h00000000;
          end
        end
        `SPIS_REG_SEQ_PARAM: begin
          img_sel_q <= reg_wdata_in[31:24];
          valid_q[new_sel] <= 1'b1;
          if (apply || (new_sel != sel)) begin
            cfg_mask_q <= 4'h0;
          end
        end
        `SPIS_REG_EXPOSURE: begin
          if (seq_en_q) begin
            cfg_mask_q[0] <= 1'b1;
            valid_q[sel]  <= 1'b1;
          end else begin
            exp_q <= reg_wdata_in[23:0];
          end
        end
        `SPIS_REG_GAIN: begin
          if (seq_en_q) begin
            cfg_mask_q[1] <= 1'b1;
            valid_q[sel]  <= 1'b1;
          end else begin
            gain_q <= reg_wdata_in[15:0];
          end
        end
        `SPIS_REG_AOI_ORIGIN: begin
          if (seq_en_q) begin
            cfg_mask_q[2] <= 1'b1;
            valid_q[sel]  <= 1'b1;
          end else begin
            origin_q <= reg_wdata_in;
          end
        end
        `SPIS_REG_AOI_SIZE: begin
          if (seq_en_q) begin
            cfg_mask_q[3] <= 1'b1;
            valid_q[sel]  <= 1'b1;
          end else begin
            size_q <= reg_wdata_in;
          end
        end
        `SPIS_REG_STAMP_CTRL: begin
          stamp_mask_q <= reg_wdata_in[10:0];
          stamp_en_q   <= reg_wdata_in[`SPIS_STAMP_EN_BIT];
          stamp_line_q <= reg_wdata_in[31:16];
        end
        `SPIS_REG_USER_VALUE: user_q <= reg_wdata_in;
        `SPIS_REG_BINNING:    bin_mode_q <= reg_wdata_in[1:0];
        default: ;
      endcase
    end
  end

  // Entry writes land only in the selected slot; other slots keep their contents.
  always @(posedge core_clk_in) begin
    if (wr_hit && seq_en_q) begin
      case (reg_addr_in)
        `SPIS_REG_EXPOSURE:   ent_exp[sel]    <= reg_wdata_in[23:0];
        `SPIS_REG_GAIN:       ent_gain[sel]   <= reg_wdata_in[15:0];
        `SPIS_REG_AOI_ORIGIN: ent_origin[sel] <= reg_wdata_in;
        `SPIS_REG_AOI_SIZE:   ent_size[sel]   <= reg_wdata_in;
        default: ;
      endcase
    end
    if (par_wr) begin
      ent_mode[new_sel] <= reg_wdata_in[15:8];
      ent_rep[new_sel]  <= reg_wdata_in[23:16];
    end
    if (apply) begin
      if (!cfg_mask_q[0] || new_sel != sel) ent_exp[new_sel]    <= `SPIS_EXP_RST_US;
      if (!cfg_mask_q[1] || new_sel != sel) ent_gain[new_sel]   <= `SPIS_GAIN_RST;
      if (!cfg_mask_q[2] || new_sel != sel) ent_origin[new_sel] <= 32'h00000000;
      if (!cfg_mask_q[3] || new_sel != sel) begin
        ent_size[new_sel] <= {`SPIS_SENSOR_H, `SPIS_SENSOR_W};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequence pointer, repeat counting and active parameter set.
  reg  [4:0]  ptr_q;
  reg  [7:0]  rep_cnt_q;
  reg  [23:0] act_exp_q;
  reg  [15:0] act_gain_q;
  reg  [31:0] act_origin_q;
  reg  [31:0] act_size_q;

  wire       use_ent  = seq_en_q && valid_q[ptr_q];
  wire [7:0] cur_mode = use_ent ? ent_mode[ptr_q] : `SPIS_STEP_INTEG;
  wire [7:0] cur_rep  = use_ent ? ent_rep[ptr_q] : 8'h01;
  wire [7:0] rep_eff  = (cur_rep == 8'h00) ? 8'h01 : cur_rep;
  wire [4:0] last_ix  = (seq_len_q == 8'h00) ? 5'd0 :
                        (seq_len_q > `SPIS_MAX_ENTRIES) ? 5'd31 : seq_len_q[4:0] - 5'd1;
  wire       perf_step = step_wr && reg_wdata_in[`SPIS_PERF_STEP_BIT];
  wire       seq_rewind = (cmd_wr && (reg_wdata_in[`SPIS_CMD_MULTI_BIT] ||
                           reg_wdata_in[`SPIS_CMD_ISO_BIT] ||
                           reg_wdata_in[`SPIS_CMD_SINGLE_BIT])) ||
                          (step_wr && reg_wdata_in[`SPIS_PERF_RESET_BIT]) || rst_rise;
  reg        step_ev;

  always @* begin
    case (cur_mode)
      `SPIS_STEP_EDGE:  step_ev = step_rise || perf_step;
      `SPIS_STEP_LEVEL: step_ev = (integ_start_in && step_s) || perf_step;
      default:          step_ev = integ_start_in;
    endcase
  end

  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ptr_q     <= 5'd0;
      rep_cnt_q <= 8'h00;
    end else if (seq_rewind || !seq_en_q) begin
      ptr_q     <= 5'd0;
      rep_cnt_q <= 8'h00;
    end else if (step_ev) begin
      if (rep_cnt_q + 8'h01 >= rep_eff) begin
        rep_cnt_q <= 8'h00;
        if (ptr_q >= last_ix) begin
          ptr_q <= auto_rst_q ? 5'd0 : last_ix;
        end else begin
          ptr_q <= ptr_q + 5'd1;
        end
      end else begin
        rep_cnt_q <= rep_cnt_q + 8'h01;
      end
    end
  end

  // The active set is frozen at integration start; stepping in the same cycle
  // only affects the next image.
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      act_exp_q    <= `SPIS_EXP_RST_US;
      act_gain_q   <= `SPIS_GAIN_RST;
      act_origin_q <= 32'h00000000;
      act_size_q   <= {`SPIS_SENSOR_H, `SPIS_SENSOR_W};
      exposure_out <= `SPIS_EXP_RST_US;
      gain_out     <= `SPIS_GAIN_RST;
      seq_index_out <= 8'h00;
    end else if (integ_start_in) begin
      act_exp_q    <= use_ent ? ent_exp[ptr_q] : exp_q;
      act_gain_q   <= use_ent ? ent_gain[ptr_q] : gain_q;
      act_origin_q <= use_ent ? ent_origin[ptr_q] : origin_q;
      act_size_q   <= use_ent ? ent_size[ptr_q] : size_q;
      exposure_out <= use_ent ? ent_exp[ptr_q] : exp_q;
      gain_out     <= use_ent ? ent_gain[ptr_q] : gain_q;
      seq_index_out <= {3'b000, ptr_q};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Counters, stamp snapshots and frame pacing.
  reg  [31:0] trig_cnt_q;
  reg  [31:0] frame_cnt_q;
  reg  [31:0] snap_cycle_q;
  reg  [31:0] snap_trig_q;
  reg  [31:0] snap_frame_q;
  reg  [7:0]  snap_io_q;
  reg  [7:0]  snap_idx_q;
  reg  [29:0] gap_q;
  reg         req_pend_q;
  wire [31:0] gap_prod = {8'h00, act_exp_q} * `SPIS_CYC_PER_US;

  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      trig_cnt_q   <= 32'h00000000;
      frame_cnt_q  <= 32'h00000000;
      snap_cycle_q <= 32'h00000000;
      snap_trig_q  <= 32'h00000000;
      snap_frame_q <= 32'h00000000;
      snap_io_q    <= 8'h00;
      snap_idx_q   <= 8'h00;
      gap_q        <= 30'h00000000;
      req_pend_q   <= 1'b0;
      frame_start_out <= 1'b0;
    end else begin
      if (trig_rise) trig_cnt_q <= trig_cnt_q + 32'h00000001;
      if (readout_done_in) frame_cnt_q <= frame_cnt_q + 32'h00000001;
      if (integ_start_in) begin
        snap_cycle_q <= cycle_time_in;
        snap_io_q    <= io_s;
        snap_trig_q  <= trig_cnt_q;
        snap_frame_q <= frame_cnt_q;
        snap_idx_q   <= seq_en_q ? {3'b000, ptr_q} : 8'h00;
      end
      // A request arriving in the launch cycle stays pending for the next frame.
      frame_start_out <= req_pend_q && (gap_q == 30'h00000000);
      if (req_pend_q && gap_q == 30'h00000000) begin
        gap_q      <= gap_prod[29:0];
        req_pend_q <= frame_req_in;
      end else begin
        if (gap_q != 30'h00000000) gap_q <= gap_q - 30'h00000001;
        if (frame_req_in) req_pend_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pixel path: centre crop, binning and stamp insertion.
  reg  [15:0] col_q;
  reg  [15:0] row_q;
  reg  [15:0] out_col_q;
  reg  [1:0]  bin_cnt_q;
  reg  [17:0] acc_q;
  reg  [31:0] stamp_item;

  wire [15:0] aoi_w   = act_size_q[15:0];
  wire [15:0] aoi_h   = act_size_q[31:16];
  wire        w_lt    = aoi_w < `SPIS_SENSOR_W;
  wire        h_lt    = aoi_h < `SPIS_SENSOR_H;
  wire        reduced = w_lt || h_lt;
  wire [15:0] eff_w   = w_lt ? aoi_w : `SPIS_SENSOR_W;
  wire [15:0] eff_h   = h_lt ? aoi_h : `SPIS_SENSOR_H;
  wire [15:0] crop_x  = w_lt ? ((`SPIS_SENSOR_W - aoi_w) >> 1) : 16'h0000;
  wire [15:0] crop_y  = h_lt ? ((`SPIS_SENSOR_H - aoi_h) >> 1) : 16'h0000;
  wire [1:0]  bin_last = reduced ? 2'd0 : (bin_mode_q == 2'd1) ? 2'd1 :
                         (bin_mode_q == 2'd2) ? 2'd3 : 2'd0;
  wire [15:0] cur_col = pix_sol_in ? 16'h0000 : col_q;
  wire [15:0] cur_row = pix_sof_in ? 16'h0000 : (pix_sol_in ? row_q + 16'h0001 : row_q);
  wire        in_win  = (cur_col >= crop_x) && (cur_row >= crop_y) &&
                        ({1'b0, cur_col} < {1'b0, crop_x} + {1'b0, eff_w}) &&
                        ({1'b0, cur_row} < {1'b0, crop_y} + {1'b0, eff_h});
  wire        first   = (cur_col == crop_x);
  wire [1:0]  bidx    = first ? 2'd0 : bin_cnt_q;
  wire [17:0] acc_nx  = (bidx == 2'd0) ? {2'b00, pix_data_in} : acc_q + {2'b00, pix_data_in};
  wire [17:0] bin_val = (bin_last == 2'd3) ? (acc_nx >> 2) :
                        (bin_last == 2'd1) ? (acc_nx >> 1) : acc_nx;
  wire [15:0] ocol    = first ? 16'h0000 : out_col_q;
  wire [15:0] out_row = cur_row - crop_y;
  wire        stamp_on = stamp_en_q && (out_row == stamp_line_q) &&
                         (ocol < `SPIS_STAMP_WORDS);
  wire [3:0]  item_ix = ocol[4:1];
  wire        item_en = (item_ix == 4'd8) ? (stamp_mask_q[8] || seq_en_q)
                                          : stamp_mask_q[item_ix];

  always @* begin
    case (item_ix)
      4'd0:    stamp_item = snap_cycle_q;
      4'd1:    stamp_item = snap_trig_q;
      4'd2:    stamp_item = snap_frame_q;
      4'd3:    stamp_item = act_origin_q;
      4'd4:    stamp_item = act_size_q;
      4'd5:    stamp_item = {8'h00, act_exp_q};
      4'd6:    stamp_item = {16'h0000, act_gain_q};
      4'd7:    stamp_item = {24'h000000, snap_io_q};
      4'd8:    stamp_item = {24'h000000, snap_idx_q};
      4'd9:    stamp_item = SERIAL_NUMBER;
      4'd10:   stamp_item = user_q;
      default: stamp_item = 32'h00000000;
    endcase
  end

  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      col_q <= 16'h0000;
      row_q <= 16'h0000;
      out_col_q <= 16'h0000;
      bin_cnt_q <= 2'd0;
      acc_q <= 18'h00000;
      pix_valid_out <= 1'b0;
      pix_sol_out <= 1'b0;
      pix_data_out <= 16'h0000;
    end else begin
      pix_valid_out <= 1'b0;
      pix_sol_out <= 1'b0;
      if (pix_valid_in) begin
        col_q <= cur_col + 16'h0001;
        row_q <= cur_row;
        if (in_win) begin
          if (bidx == bin_last) begin
            bin_cnt_q <= 2'd0;
            out_col_q <= ocol + 16'h0001;
            pix_valid_out <= 1'b1;
            pix_sol_out <= (ocol == 16'h0000);
            if (stamp_on) begin
              pix_data_out <= !item_en ? 16'h0000 :
                              (ocol[0] ? stamp_item[15:0] : stamp_item[31:16]);
            end else begin
              pix_data_out <= bin_val[15:0];
            end
          end else begin
            bin_cnt_q <= bidx + 2'd1;
            out_col_q <= ocol;
            acc_q <= acc_nx;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register reads; entry contents are write-only.
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= 32'h00000000;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `SPIS_REG_SEQ_CTRL:    reg_rdata_out <= {`SPIS_MAX_ENTRIES, seq_len_q, 14'h0000,
                                                 auto_rst_q, seq_en_q};
        `SPIS_REG_SEQ_PARAM:   reg_rdata_out <= {img_sel_q, 24'h000000};
        `SPIS_REG_SEQ_STEP:    reg_rdata_out <= {3'b000, ptr_q, 24'h000000};
        `SPIS_REG_EXPOSURE:    reg_rdata_out <= {8'h00, exp_q};
        `SPIS_REG_GAIN:        reg_rdata_out <= {16'h0000, gain_q};
        `SPIS_REG_AOI_ORIGIN:  reg_rdata_out <= origin_q;
        `SPIS_REG_AOI_SIZE:    reg_rdata_out <= size_q;
        `SPIS_REG_STAMP_CTRL:  reg_rdata_out <= {stamp_line_q, stamp_en_q, 4'h0, stamp_mask_q};
        `SPIS_REG_USER_VALUE:  reg_rdata_out <= user_q;
        `SPIS_REG_TRIG_COUNT:  reg_rdata_out <= trig_cnt_q;
        `SPIS_REG_FRAME_COUNT: reg_rdata_out <= frame_cnt_q;
        `SPIS_REG_SERIAL:      reg_rdata_out <= SERIAL_NUMBER;
        `SPIS_REG_BINNING:     reg_rdata_out <= {30'h00000000, bin_mode_q};
        `SPIS_REG_CYCLE_SNAP:  reg_rdata_out <= snap_cycle_q;
        default:               reg_rdata_out <= 32'h00000000;
      endcase
    end
  end
endmodule

// file: dv/spis_props.sv
// Purpose: Port-level checks for spis_top.
// Assumes: One core clock; reset clears all state except entry storage.
// Notes:   The bench never reads the frame count in a readout cycle.
`timescale 1ns/1ps
module spis_props (
  input wire        core_clk_in,
  input wire        rstn_in,
  input wire [7:0]  reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire        reg_wr_in,
  input wire        reg_rd_in,
  input wire [31:0] reg_rdata_out,
  input wire        integ_start_in,
  input wire        readout_done_in,
  input wire        frame_start_out,
  input wire [23:0] exposure_out,
  input wire [15:0] gain_out,
  input wire [7:0]  seq_index_out,
  input wire        pix_valid_in,
  input wire        pix_valid_out,
  input wire        pix_sol_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  reg [31:0] n_rd_q;
  always @(posedge core_clk_in or negedge rstn_in)
    if (!rstn_in) n_rd_q <= 32'h0;
    else if (readout_done_in) n_rd_q <= n_rd_q + 32'h1;
  sequence s_cmd; reg_wr_in && reg_addr_in == 8'h0c && reg_wdata_in[2:0] != 3'h0; endsequence
  sequence s_rewind; s_cmd ##1 integ_start_in; endsequence
  property p_rewind; s_rewind |=> seq_index_out == 8'h00; endproperty
  a_rewind: assert property (p_rewind) else $error("index not rewound");
  property p_frames; reg_rd_in && reg_addr_in == 8'h2c |=> reg_rdata_out == n_rd_q; endproperty
  a_frames: assert property (p_frames) else $error("frame count wrong");
  property p_hold; !integ_start_in |=> $stable({exposure_out,gain_out,seq_index_out}); endproperty
  a_hold: assert property (p_hold) else $error("set moved off integration");
  property p_noread; reg_rd_in && reg_addr_in == 8'h04 |=> reg_rdata_out[23:0] == 24'h0; endproperty
  a_noread: assert property (p_noread) else $error("entry readback seen");
  property p_gap; frame_start_out |=> !frame_start_out [*8]; endproperty
  a_gap: assert property (p_gap) else $error("frame starts too close");
  property p_pix; pix_valid_out |-> $past(pix_valid_in); endproperty
  a_pix: assert property (p_pix) else $error("pixel without input");
  property p_sol; pix_sol_out |-> pix_valid_out; endproperty
  a_sol: assert property (p_sol) else $error("line start without pixel");
  property p_stand; !reg_rd_in |=> $stable(reg_rdata_out); endproperty
  a_stand: assert property (p_stand) else $error("read data moved");
endmodule
bind spis_top spis_props spis_props_inst (.*);

// file: dv/spis_sensor_model.sv
// Purpose: Sensor timing seen by spis_top.
// Assumes: Same clock as the block.
// Notes:   Readout follows each integration a few cycles later.
`timescale 1ns/1ps
module spis_sensor_model (
  input  wire core_clk_in,
  input  wire shot_in,
  output reg  integ_start_out = 1'b0,
  output reg  readout_done_out = 1'b0
);
  reg [2:0] dly_q = 3'h0;
  always @(posedge core_clk_in) begin
    integ_start_out <= shot_in;
    dly_q <= {dly_q[1:0], integ_start_out};
    readout_done_out <= dly_q[2];
  end
endmodule

// file: dv/spis_top_tb.sv
// Purpose: Register-driven tests of spis_top.
// Assumes: 40 MHz clock; stamp only on line 0.
// Notes:   Accesses take two cycles so strobes never retoggle in one step.
`timescale 1ns/1ps
module spis_top_tb;
  reg         core_clk_in = 1'b0, rstn_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  reg         shot_q = 1'b0, ext_trigger_in = 1'b0, frame_req_in = 1'b0, pix_valid_in = 1'b0;
  reg         pix_sof_in = 1'b0, pix_sol_in = 1'b0;
  reg  [7:0]  reg_addr_in = 8'h00, m;
  reg  [15:0] pix_data_in = 16'h0000, pix_last;
  reg  [23:0] e2;
  reg  [31:0] reg_wdata_in = 32'h0, cyc_q = 32'h0, snap;
  wire [31:0] reg_rdata_out;
  wire        integ_start_in, readout_done_in, frame_start_out, pix_valid_out, pix_sol_out;
  wire [23:0] exposure_out;
  wire [15:0] gain_out, pix_data_out;
  wire [7:0]  seq_index_out;
  integer     bad_count = 0, n_tests = 0, fs_n = 0, k, i;
  spis_top spis_top_inst (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .ext_step_in(1'b0),
    .ext_seq_reset_in(1'b0), .ext_trigger_in(ext_trigger_in), .io_lines_in(8'h00),
    .integ_start_in(integ_start_in), .readout_done_in(readout_done_in),
    .frame_req_in(frame_req_in), .cycle_time_in(cyc_q), .frame_start_out(frame_start_out),
    .exposure_out(exposure_out), .gain_out(gain_out), .seq_index_out(seq_index_out),
    .pix_valid_in(pix_valid_in), .pix_sof_in(pix_sof_in), .pix_sol_in(pix_sol_in),
    .pix_data_in(pix_data_in), .pix_valid_out(pix_valid_out), .pix_sol_out(pix_sol_out),
    .pix_data_out(pix_data_out));
  spis_sensor_model spis_sensor_model_inst (.core_clk_in(core_clk_in), .shot_in(shot_q),
    .integ_start_out(integ_start_in), .readout_done_out(readout_done_in));
  always #12.5 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    cyc_q <= cyc_q + 32'h1;
    if (integ_start_in === 1'b1) snap <= cyc_q;
    if (frame_start_out === 1'b1) fs_n <= fs_n + 1;
    if (pix_valid_out === 1'b1) pix_last <= pix_data_out;
  end
  task chk(input string nm, input [31:0] e, input [31:0] g); begin
    n_tests = n_tests + 1;
    if (g !== e) begin
      bad_count = bad_count + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  end endtask
  task wr(input [7:0] a, input [31:0] d); begin
    reg_addr_in <= a; reg_wdata_in <= d; reg_wr_in <= 1'b1;
    @(posedge core_clk_in); reg_wr_in <= 1'b0; @(posedge core_clk_in);
  end endtask
  task rc(input [7:0] a, input [31:0] e, input string nm); begin
    reg_addr_in <= a; reg_rd_in <= 1'b1;
    @(posedge core_clk_in); reg_rd_in <= 1'b0; @(posedge core_clk_in);
    chk(nm, e, reg_rdata_out);
  end endtask
  task shot(input [2:0] c, input [23:0] e); begin
    shot_q <= 1'b1;
    if (c != 3'h0) begin
      reg_addr_in <= 8'h0c; reg_wdata_in <= {29'h0, c}; reg_wr_in <= 1'b1;
    end
    @(posedge core_clk_in); shot_q <= 1'b0; reg_wr_in <= 1'b0;
    repeat (6) @(posedge core_clk_in);
    chk("exposure", {8'h0, e}, {8'h0, exposure_out});
  end endtask
  task pix(input [15:0] d, input f); begin
    pix_valid_in <= 1'b1; pix_sof_in <= f; pix_sol_in <= f; pix_data_in <= d;
    @(posedge core_clk_in); pix_valid_in <= 1'b0; repeat (2) @(posedge core_clk_in);
  end endtask
  task tally_and_finish; begin
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end endtask
  initial begin
    repeat (3) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    @(posedge core_clk_in);
    chk("exposure", 32'h9c40, {8'h0, exposure_out});
    rc(8'h2c, 32'h0, "frames");
    rc(8'h28, 32'h0, "triggers");
    repeat (3) begin
      ext_trigger_in <= 1'b1; repeat (4) @(posedge core_clk_in);
      ext_trigger_in <= 1'b0; repeat (4) @(posedge core_clk_in);
    end
    rc(8'h28, 32'h3, "triggers");
    // The second request falls inside the default exposure gap and must stay pending.
    repeat (2) begin
      frame_req_in <= 1'b1; @(posedge core_clk_in);
      frame_req_in <= 1'b0; repeat (20) @(posedge core_clk_in);
    end
    chk("frame starts", 32'h1, fs_n);
    wr(8'h00, 32'h00020001);
    for (k = 0; k < 4; k = k + 1) begin
      m = (k == 0) ? 8'h80 : (k == 1) ? 8'h33 : (k == 2) ? 8'h82 : 8'h84;
      e2 = (k < 2) ? 24'd20 : 24'd10;
      for (i = 0; i < 2; i = i + 1) begin
        wr(8'h04, {i[7:0], 8'h00, m, 8'h00});
        wr(8'h10, 10 * (i + 1));
      end
      shot(k[0] ? 3'h4 : 3'h2, 24'd10);
      shot(3'h0, e2);
      shot(3'h0, e2);
      wr(8'h08, 32'h20);
      shot(3'h0, 24'd20);
      shot(3'h1, 24'd10);
    end
    rc(8'h10, 32'h9c40, "plain exposure");
    rc(8'h04, 32'h01000000, "entry select");
    wr(8'h04, 32'h20);
    shot(3'h2, 24'h9c40);
    rc(8'h38, snap, "cycle snapshot");
    wr(8'h00, 32'h0);
    shot(3'h2, 24'h9c40);
    rc(8'h2c, 32'd22, "frames");
    pix(16'h0123, 1'b1);
    chk("pixel", 32'h0123, {16'h0, pix_last});
    wr(8'h34, 32'h1);
    pix(16'h0004, 1'b1);
    pix(16'h0008, 1'b0);
    chk("binned", 32'h0006, {16'h0, pix_last});
    wr(8'h20, 32'h8001);
    pix(16'h0, 1'b1);
    repeat (3) pix(16'h0, 1'b0);
    chk("stamp", {16'h0, snap[15:0]}, {16'h0, pix_last});
    tally_and_finish;
  end
  initial begin
    #200000;
    bad_count = bad_count + 1;
    tally_and_finish;
  end
endmodule
